// ===== design/cfg_consts.vh
`ifndef CFG_CONSTS_VH
`define CFG_CONSTS_VH
`define CFG_WIDTH 14
`define FRAME_BITS 16
`define FRAME_CNT_W 5
`define CFG_RESET 14'h0000
`define POS_RESET 4'h1
`define NEG_RESET 4'h2
`define GROUND_CODE 4'h0
`define ADDR_NONE 2'h0
`define ADDR_TEST 2'h1
`define ADDR_CALREG 2'h2
`define ADDR_CONFIG 2'h3
`define BIT_PAIRING 13
`define BIT_CHAN_HI 12
`define BIT_CHAN_LO 10
`define BIT_POWER_HI 9
`define BIT_POWER_LO 8
`define BIT_READ_HI 7
`define BIT_READ_LO 6
`define BIT_IFMODE 5
`define BIT_CONV 4
`define BIT_CALKIND 3
`define BIT_CALSEL_HI 2
`define BIT_CALSEL_LO 1
`define BIT_CALGO 0
`define READ_RESULT 2'h0
`define READ_TEST 2'h1
`define READ_CALREG 2'h2
`define READ_STATUS 2'h3
`define CAL_FULL 2'h0
`define CAL_GAIN_OFFSET 2'h1
`define CAL_OFFSET 2'h2
`define CAL_GAIN 2'h3
`define STEP_NONE 3'h0
`define STEP_DAC 3'h1
`define STEP_GAIN 3'h2
`define STEP_OFFSET 3'h4
`endif

// ===== design/converter_config.v
`timescale 1ns/1ns
`include "cfg_consts.vh"
module converter_config (
  input wire mclk,
  input wire srst,
  input wire frame_sel_n,
  input wire serial_clk,
  input wire serial_din,
  input wire read_cycle_done,
  input wire conversion_done,
  input wire calibration_done,
  input wire sleep_n,
  output reg [`CFG_WIDTH-1:0] config_word_ff,
  output reg input_pairing_bit_ff,
  output reg [2:0] chan_code_ff,
  output reg [3:0] positive_sample_input_ff,
  output reg [3:0] negative_sample_input_ff,
  output reg negative_is_analog_ground_ff,
  output reg [1:0] power_field_ff,
  output reg power_down_req_ff,
  output reg [1:0] read_target_ff,
  output reg two_wire_mode_ff,
  output reg soft_conversion_trigger_ff,
  output reg conversion_start_ff,
  output reg calibration_kind_bit_ff,
  output reg [1:0] calibration_select_ff,
  output reg calibration_go_bit_ff,
  output reg calibration_start_ff,
  output reg [2:0] calibration_steps_ff,
  output reg [1:0] coeff_address_ff,
  output reg test_write_ff,
  output reg calreg_write_ff,
  output reg [`CFG_WIDTH-1:0] frame_data_ff
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  reg [2:0] sync1_ff;
  reg [2:0] sync2_ff;
  reg sclk_prev_ff;
  // the sleep pin is asynchronous too and passes two stages of its own
  reg sleep_meta_ff;
  reg sleep_sync_ff;
  wire frame_active = ~sync2_ff[0];
  wire bit_strobe = sync2_ff[1] & ~sclk_prev_ff;

  always @(posedge mclk) begin
    if (srst) begin
      sync1_ff <= 3'h1;
      sync2_ff <= 3'h1;
      sclk_prev_ff <= 1'b0;
      sleep_meta_ff <= 1'b1;
      sleep_sync_ff <= 1'b1;
    end else begin
      sync1_ff <= {serial_din, serial_clk, frame_sel_n};
      sync2_ff <= sync1_ff;
      sclk_prev_ff <= sync2_ff[1];
      sleep_meta_ff <= sleep_n;
      sleep_sync_ff <= sleep_meta_ff;
    end
  end

  wire frame_done;
  wire [`FRAME_BITS-1:0] frame_word;

  frame_shifter #(
    .FRAME_BITS(`FRAME_BITS)
  ) u_shift (
    .mclk(mclk),
    .srst(srst),
    .frame_active(frame_active),
    .bit_strobe(bit_strobe),
    .bit_value(sync2_ff[2]),
    .frame_done_ff(frame_done),
    .frame_word_ff(frame_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function [3:0] pos_input;
    input [2:0] code;
    begin
      // inputs numbered 1..8; upper code half swaps the pair
      pos_input = {1'b0, code[1:0], 1'b0} + (code[2] ? 4'h2 : 4'h1);
    end
  endfunction

  function [3:0] neg_input;
    input [2:0] code;
    begin
      neg_input = {1'b0, code[1:0], 1'b0} + (code[2] ? 4'h1 : 4'h2);
    end
  endfunction

  function [2:0] cal_steps;
    input [1:0] sel;
    begin
      case (sel)
        `CAL_FULL: cal_steps = `STEP_DAC | `STEP_GAIN | `STEP_OFFSET;
        `CAL_GAIN_OFFSET: cal_steps = `STEP_GAIN | `STEP_OFFSET;
        `CAL_OFFSET: cal_steps = `STEP_OFFSET;
        `CAL_GAIN: cal_steps = `STEP_GAIN;
        default: cal_steps = `STEP_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration word
  wire [1:0] frame_addr = frame_word[`FRAME_BITS-1:`FRAME_BITS-2];
  wire [`CFG_WIDTH-1:0] frame_data = frame_word[`CFG_WIDTH-1:0];
  wire cfg_write = frame_done && (frame_addr == `ADDR_CONFIG);
  reg [`CFG_WIDTH-1:0] nxt_config_word;

  always @* begin
    nxt_config_word = config_word_ff;
    // hardware clears act first so a write in the same cycle wins
    if (read_cycle_done) begin
      nxt_config_word[`BIT_IFMODE] = 1'b0;
    end
    if (conversion_done) begin
      nxt_config_word[`BIT_CONV] = 1'b0;
    end
    if (calibration_done) begin
      nxt_config_word[`BIT_CALGO] = 1'b0;
    end
    // address 00, test and calibration frames never touch the word
    if (cfg_write) begin
      nxt_config_word = frame_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered decode of the word
  wire [2:0] chan = nxt_config_word[`BIT_CHAN_HI:`BIT_CHAN_LO];
  wire single_ended = nxt_config_word[`BIT_PAIRING];
  wire cal_go = nxt_config_word[`BIT_CALGO];
  wire [1:0] cal_sel = nxt_config_word[`BIT_CALSEL_HI:`BIT_CALSEL_LO];
  wire [1:0] power_field = nxt_config_word[`BIT_POWER_HI:`BIT_POWER_LO];

  always @(posedge mclk) begin
    if (srst) begin
      config_word_ff <= `CFG_RESET;
      input_pairing_bit_ff <= 1'b0;
      chan_code_ff <= 3'h0;
      // all-zero code: input 1 positive, input 2 negative
      positive_sample_input_ff <= `POS_RESET;
      negative_sample_input_ff <= `NEG_RESET;
      negative_is_analog_ground_ff <= 1'b0;
      power_field_ff <= 2'h0;
      power_down_req_ff <= 1'b0;
      read_target_ff <= `READ_RESULT;
      two_wire_mode_ff <= 1'b0;
      soft_conversion_trigger_ff <= 1'b0;
      conversion_start_ff <= 1'b0;
      calibration_kind_bit_ff <= 1'b0;
      calibration_select_ff <= 2'h0;
      calibration_go_bit_ff <= 1'b0;
      calibration_start_ff <= 1'b0;
      calibration_steps_ff <= `STEP_NONE;
      coeff_address_ff <= 2'h0;
      test_write_ff <= 1'b0;
      calreg_write_ff <= 1'b0;
      frame_data_ff <= 14'h0000;
    end else begin
      config_word_ff <= nxt_config_word;
      input_pairing_bit_ff <= single_ended;
      chan_code_ff <= chan;
      positive_sample_input_ff <= pos_input(chan);
      // single-ended: negative side is analog ground, coded as 0
      negative_sample_input_ff <= single_ended ? `GROUND_CODE : neg_input(chan);
      negative_is_analog_ground_ff <= single_ended;
      power_field_ff <= power_field;
      // any nonzero field or a low sleep pin asks for some power-down mode
      power_down_req_ff <= (power_field != 2'h0) | ~sleep_sync_ff;
      read_target_ff <= nxt_config_word[`BIT_READ_HI:`BIT_READ_LO];
      two_wire_mode_ff <= nxt_config_word[`BIT_IFMODE];
      soft_conversion_trigger_ff <= nxt_config_word[`BIT_CONV];
      conversion_start_ff <= cfg_write & frame_data[`BIT_CONV];
      calibration_kind_bit_ff <= nxt_config_word[`BIT_CALKIND];
      calibration_select_ff <= cal_sel;
      calibration_go_bit_ff <= cal_go;
      calibration_start_ff <= cfg_write & frame_data[`BIT_CALGO];
      // same step order for both kinds; the kind bit picks internal or system
      calibration_steps_ff <= cal_go ? cal_steps(cal_sel) : `STEP_NONE;
      coeff_address_ff <= cal_go ? coeff_address_ff : cal_sel;
      test_write_ff <= frame_done && (frame_addr == `ADDR_TEST);
      calreg_write_ff <= frame_done && (frame_addr == `ADDR_CALREG);
      frame_data_ff <= frame_data;
    end
  end
endmodule // converter_config

// ===== design/frame_shifter.v
`timescale 1ns/1ns
`include "cfg_consts.vh"
// collects one 16-bit write frame from synchronised serial pins, msb first
module frame_shifter #(
  parameter FRAME_BITS = `FRAME_BITS
) (
  input wire mclk,
  input wire srst,
  input wire frame_active,
  input wire bit_strobe,
  input wire bit_value,
  output reg frame_done_ff,
  output reg [FRAME_BITS-1:0] frame_word_ff
);
  reg [`FRAME_CNT_W-1:0] count_ff;
  reg [FRAME_BITS-1:0] shift_ff;
  wire [FRAME_BITS-1:0] nxt_shift = {shift_ff[FRAME_BITS-2:0], bit_value};

  always @(posedge mclk) begin
    if (srst) begin
      count_ff <= 5'h00;
      shift_ff <= {FRAME_BITS{1'b0}};
      frame_done_ff <= 1'b0;
      frame_word_ff <= {FRAME_BITS{1'b0}};
    end else begin
      frame_done_ff <= 1'b0;
      if (!frame_active) begin
        // a short frame is dropped whole
        count_ff <= 5'h00;
      end else if (bit_strobe) begin
        shift_ff <= nxt_shift;
        if (count_ff == FRAME_BITS - 1) begin
          // latch only once all bits are in
          frame_word_ff <= nxt_shift;
          frame_done_ff <= 1'b1;
          count_ff <= 5'h00;
        end else begin
          count_ff <= count_ff + 5'h01;
        end
      end
    end
  end
endmodule // frame_shifter

// ===== test/converter_config_asserts.sv
`timescale 1ns/1ns
module converter_config_asserts (
  input logic mclk, srst, read_cycle_done, conversion_done, calibration_done,
  input logic input_pairing_bit_ff, negative_is_analog_ground_ff, two_wire_mode_ff,
  input logic soft_conversion_trigger_ff, conversion_start_ff, calibration_go_bit_ff,
  input logic calibration_start_ff, test_write_ff, calreg_write_ff,
  input logic [13:0] config_word_ff,
  input logic [2:0] chan_code_ff, calibration_steps_ff,
  input logic [3:0] positive_sample_input_ff, negative_sample_input_ff,
  input logic [1:0] calibration_select_ff
);
  wire [3:0] pair_lo = {1'b0, chan_code_ff[1:0], 1'b0} + 4'h1;
  wire [1:0] cs = calibration_select_ff;
  wire [2:0] steps_exp = cs[1] ? (cs[0] ? 3'h2 : 3'h4) : (cs[0] ? 3'h6 : 3'h7);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // a start strobe comes with its setting bit and lasts one cycle
  sequence strobe_with(s, lvl);
    s && lvl ##1 !s;
  endsequence
  AST_RESET_VALUES:
    assert property (disable iff (1'b0) srst |=> config_word_ff == 14'h0000
      && positive_sample_input_ff == 4'h1 && negative_sample_input_ff == 4'h2)
    else $error("reset values wrong");
  AST_CHAN_FIELDS:
    assert property (input_pairing_bit_ff == config_word_ff[13]
      && chan_code_ff == config_word_ff[12:10]) else $error("channel fields wrong");
  AST_CHAN_MAP:
    assert property (positive_sample_input_ff == pair_lo + chan_code_ff[2]
      && negative_is_analog_ground_ff == input_pairing_bit_ff && negative_sample_input_ff
      == (input_pairing_bit_ff ? 4'h0 : pair_lo + !chan_code_ff[2])) else $error("input map");
  AST_IF_CLEAR:
    assert property (read_cycle_done |=> !two_wire_mode_ff) else $error("mode bit kept");
  AST_CONV_STROBE:
    assert property (conversion_start_ff |-> strobe_with(conversion_start_ff,
      soft_conversion_trigger_ff)) else $error("conversion strobe wrong");
  AST_CONV_CLEAR:
    assert property (conversion_done |=> !soft_conversion_trigger_ff || conversion_start_ff)
    else $error("conversion bit kept");
  AST_CAL_STROBE:
    assert property (calibration_start_ff |-> strobe_with(calibration_start_ff,
      calibration_go_bit_ff)) else $error("calibration strobe wrong");
  AST_CAL_CLEAR:
    assert property (calibration_done |=> !calibration_go_bit_ff || calibration_start_ff)
    else $error("calibration bit kept");
  AST_CAL_STEPS:
    assert property (calibration_steps_ff == (calibration_go_bit_ff ? steps_exp : 3'h0))
    else $error("calibration steps wrong");
  AST_OTHER_HOLD:
    assert property (test_write_ff || calreg_write_ff |-> $stable(config_word_ff))
    else $error("word changed by other frame");
endmodule // converter_config_asserts
bind converter_config converter_config_asserts u_converter_config_asserts (.*);

// ===== test/converter_config_tb.sv
`timescale 1ns/1ns
module converter_config_tb;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg sleep_n = 1'b1;
  reg read_cycle_done = 1'b0, conversion_done = 1'b0, calibration_done = 1'b0;
  wire fs, sc, sd, gnd, preq, twm, conv, cst, kind, go, calst, tw, cw;
  wire [13:0] word, fdat;
  wire [3:0] pos, neg;
  wire [2:0] steps;
  wire [1:0] pwr, rdt, coef;
  integer n_mismatch = 0, checked = 0, cycles = 0, n_conv = 0, n_cal = 0, n_tw = 0, n_cw = 0;
  integer i;
  reg [3:0] e;
  always #20 mclk = ~mclk;
  host_model u_host_model (.mclk(mclk), .frame_sel_n(fs), .serial_clk(sc), .serial_din(sd));
  converter_config u_converter_config (.mclk(mclk), .srst(srst), .frame_sel_n(fs),
    .serial_clk(sc), .serial_din(sd), .read_cycle_done(read_cycle_done),
    .conversion_done(conversion_done), .calibration_done(calibration_done), .sleep_n(sleep_n),
    .config_word_ff(word), .input_pairing_bit_ff(), .chan_code_ff(),
    .positive_sample_input_ff(pos), .negative_sample_input_ff(neg),
    .negative_is_analog_ground_ff(gnd), .power_field_ff(pwr), .power_down_req_ff(preq),
    .read_target_ff(rdt), .two_wire_mode_ff(twm), .soft_conversion_trigger_ff(conv),
    .conversion_start_ff(cst), .calibration_kind_bit_ff(kind), .calibration_select_ff(),
    .calibration_go_bit_ff(go), .calibration_start_ff(calst), .calibration_steps_ff(steps),
    .coeff_address_ff(coef), .test_write_ff(tw), .calreg_write_ff(cw), .frame_data_ff(fdat));
  task tally_and_finish;
    begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cycles = cycles + 1;
    n_conv = n_conv + cst;
    n_cal = n_cal + calst;
    n_tw = n_tw + tw;
    n_cw = n_cw + cw;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  task chk(input string nm, input [13:0] x, input [13:0] g);
    begin
      checked = checked + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s exp %0h got %0h", nm, x, g);
      end
    end
  endtask
  task wr(input [1:0] a, input [13:0] d);
    u_host_model.send({a, d}, 16);
  endtask
  task pulse(input [2:0] k);
    begin
      {read_cycle_done, conversion_done, calibration_done} = k;
      @(posedge mclk) #1;
      {read_cycle_done, conversion_done, calibration_done} = 3'h0;
      repeat (3) @(posedge mclk);
      #1;
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    chk("word", 14'h0000, word);
    chk("pos", 4'h1, pos);
    chk("neg", 4'h2, neg);
    chk("rdt", 2'h0, rdt);
    for (i = 0; i < 16; i = i + 1) begin
      wr(2'h3, {i[3:0], 10'h000});
      e = {1'b0, i[1:0], 1'b0} + 4'h1;
      chk("pos", e + i[2], pos);
      chk("neg", i[3] ? 4'h0 : e + !i[2], neg);
      chk("gnd", i[3], gnd);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(2'h3, {6'h00, i[1:0], 6'h00});
      chk("rdt", i[1:0], rdt);
    end
    wr(2'h0, 14'h3FFF);
    wr(2'h1, 14'h0155);
    chk("fdat", 14'h0155, fdat);
    wr(2'h2, 14'h02AA);
    chk("fdat", 14'h02AA, fdat);
    u_host_model.send(16'hFFFF, 10);
    chk("fdat", 14'h02AA, fdat);
    chk("word", 14'h00C0, word);
    chk("rdt", 2'h3, rdt);
    chk("tw", 1, n_tw);
    chk("cw", 1, n_cw);
    wr(2'h3, 14'h0200);
    chk("pwr", 2'h2, pwr);
    chk("preq", 1, preq);
    wr(2'h3, 14'h0000);
    chk("preq", 0, preq);
    sleep_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk("preq", 1, preq);
    sleep_n = 1'b1;
    wr(2'h3, 14'h0020);
    chk("twm", 1, twm);
    chk("preq", 0, preq);
    pulse(3'h4);
    chk("twm", 0, twm);
    wr(2'h3, 14'h0010);
    chk("conv", 1, conv);
    chk("nconv", 1, n_conv);
    pulse(3'h2);
    chk("conv", 0, conv);
    for (i = 0; i < 8; i = i + 1) begin
      wr(2'h3, {10'h000, i[2:0], 1'b1});
      chk("go", 1, go);
      chk("kind", i[2], kind);
      chk("steps", i[1] ? (i[0] ? 3'h2 : 3'h4) : (i[0] ? 3'h6 : 3'h7), steps);
      pulse(3'h1);
      chk("go", 0, go);
      chk("coef", i[1:0], coef);
    end
    chk("ncal", 8, n_cal);
    // a write with the start bit clear addresses a coefficient register directly
    wr(2'h3, 14'h00C4);
    chk("coef", 2'h2, coef);
    chk("steps", 3'h0, steps);
    chk("ncal", 8, n_cal);
    // mid-run reset must bring every setting back to its power-up value
    srst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    chk("word", 14'h0000, word);
    chk("pos", 4'h1, pos);
    chk("neg", 4'h2, neg);
    chk("rdt", 2'h0, rdt);
    chk("coef", 2'h0, coef);
    tally_and_finish;
  end
endmodule // converter_config_tb

// ===== test/host_model.sv
`timescale 1ns/1ns
// host side of the serial configuration port
module host_model (
  input wire mclk,
  output reg frame_sel_n,
  output reg serial_clk,
  output reg serial_din
);
  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_din = 1'b0;
  end
  // sends nb bits of w msb first; fewer than 16 aborts the frame
  task send(input [15:0] w, input integer nb);
    integer i;
    begin
      frame_sel_n = 1'b0;
      for (i = 15; i > 15 - nb; i = i - 1) begin
        serial_din = w[i];
        repeat (4) @(posedge mclk);
        #1 serial_clk = 1'b1;
        repeat (4) @(posedge mclk);
        #1 serial_clk = 1'b0;
      end
      frame_sel_n = 1'b1;
      // a released line must not keep showing the last bit
      serial_din = ~serial_din;
      repeat (8) @(posedge mclk);
      #1;
    end
  endtask
endmodule // host_model
